// ===== rtl/sgmii_mgmt_pkg.sv
// Constants for the SGMII management control and status registers.
// Assumes a single 125 MHz management clock.
package sgmii_mgmt_pkg;

    localparam int unsigned CLOCK_PERIOD_NS = 8;
    // Link timer of the auto-negotiation sync check, in its own unit
    localparam int unsigned LINK_TIMER_NS = 1600000;
    localparam int unsigned LINK_TIMER_CYCLES = LINK_TIMER_NS / CLOCK_PERIOD_NS;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // Register indices on the management port
    localparam logic [4:0] ADDR_CONTROL_LOW = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h01;

    // Control register field positions and reset values
    localparam int unsigned CTL_SPEED_MSB_BIT = 6;
    localparam int unsigned CTL_UNIDIR_BIT = 5;
    localparam logic CTL_SPEED_MSB_RESET = 1'b1;
    localparam logic CTL_UNIDIR_RESET = 1'b0;

    // Status register field positions
    localparam int unsigned ST_EXT_STATUS_BIT = 8;
    localparam int unsigned ST_UNIDIR_ABLE_BIT = 7;
    localparam int unsigned ST_PREAMBLE_SUP_BIT = 6;
    localparam int unsigned ST_AN_COMPLETE_BIT = 5;
    localparam int unsigned ST_REMOTE_FAULT_BIT = 4;
    localparam int unsigned ST_AN_ABLE_BIT = 3;
    localparam int unsigned ST_LINK_BIT = 2;
    localparam logic ST_REMOTE_FAULT_RESET = 1'b0;
    localparam logic ST_LINK_RESET = 1'b0;

    typedef enum logic [1:0] {
        SYNC_DOWN,
        SYNC_UP,
        SYNC_LOSING
    } sync_state_t;

endpackage

// ===== rtl/link_qual_if.sv
// Carrier between the register bank and the sync-loss filter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface link_qual_if;
    logic syncRaw;
    logic syncQualified;
    modport bank (output syncRaw, input syncQualified);
    modport filter (input syncRaw, output syncQualified);
endinterface
`default_nettype wire

// ===== rtl/sync_loss_filter.sv
// Holds sync as good until it has been lost for a whole link timer.
// Assumes sync input is synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module sync_loss_filter
    import sgmii_mgmt_pkg::*;
#(
    parameter int unsigned TIMER_CYCLES = LINK_TIMER_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Carrier
    link_qual_if.filter lq
);

    localparam int unsigned CNT_W = $clog2(TIMER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMER_CYCLES - 1);

    sync_state_t state;
    logic [CNT_W-1:0] lossCount;

    ////////////////////////////////////////////////////////////////////////////
    // Sync qualification

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SYNC_DOWN;
            lossCount <= '0;
        end else begin
            case (state)
                SYNC_DOWN: begin
                    lossCount <= '0;
                    if (lq.syncRaw) begin
                        state <= SYNC_UP;
                    end
                end
                SYNC_UP: begin
                    lossCount <= '0;
                    if (!lq.syncRaw) begin
                        state <= SYNC_LOSING;
                    end
                end
                SYNC_LOSING: begin
                    // Any return of sync restarts the wait
                    if (lq.syncRaw) begin
                        state <= SYNC_UP;
                        lossCount <= '0;
                    end else if (lossCount == CNT_LAST) begin
                        state <= SYNC_DOWN;
                        lossCount <= '0;
                    end else begin
                        lossCount <= lossCount + 1'b1;
                    end
                end
                default: begin
                    state <= SYNC_DOWN;
                    lossCount <= '0;
                end
            endcase
        end
    end

    assign lq.syncQualified = (state != SYNC_DOWN);

endmodule
`default_nettype wire

// ===== rtl/sgmii_mgmt_regs.sv
// Control (low bits) and status registers of the SGMII management space.
// Assumes the serial management frame decoder outside delivers one-cycle
// read and write strobes with register address and data.
`timescale 1ns/1ps
`default_nettype none
module sgmii_mgmt_regs
    import sgmii_mgmt_pkg::*;
#(
    parameter int unsigned LINK_TIMER = LINK_TIMER_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Management access
    input wire logic mgmtWrite,
    input wire logic mgmtRead,
    input wire logic [ADDR_W-1:0] mgmtAddr,
    input wire logic [DATA_W-1:0] mgmtWdata,
    output logic [DATA_W-1:0] mgmtRdata,
    output logic mgmtRvalid,
    // Mode
    input wire logic controllerMode,
    // Link state from the PCS
    input wire logic syncStatus,
    input wire logic anEnable,
    input wire logic anComplete,
    input wire logic resetDone,
    input wire logic remoteFaultEvent,
    // Control outputs
    output logic speedSelectMsb,
    output logic unidirEnable
);

    function automatic logic isReg(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] target);
        isReg = (addr == target);
    endfunction

    // Only bits 6 and 5 are backed by storage
    function automatic logic controlBit(input int unsigned pos,
                                        input logic speed,
                                        input logic unidir);
        if (pos == CTL_SPEED_MSB_BIT) begin
            controlBit = speed;
        end else if (pos == CTL_UNIDIR_BIT) begin
            controlBit = unidir;
        end else begin
            controlBit = 1'b0;
        end
    endfunction

    // Ability bits are constants of this core
    function automatic logic fixedStatusBit(input int unsigned pos);
        if (pos == ST_EXT_STATUS_BIT) begin
            fixedStatusBit = 1'b1;
        end else if (pos == ST_UNIDIR_ABLE_BIT) begin
            fixedStatusBit = 1'b1;
        end else if (pos == ST_PREAMBLE_SUP_BIT) begin
            fixedStatusBit = 1'b1;
        end else if (pos == ST_AN_ABLE_BIT) begin
            fixedStatusBit = 1'b1;
        end else begin
            fixedStatusBit = 1'b0;
        end
    endfunction

    link_qual_if lq();

    logic speedMsbStore;
    logic remoteFault;
    logic linkLatched;
    logic linkGood;
    logic statusRead;
    logic controlWrite;
    logic negotiationOk;
    logic speedWrite;
    wire logic [DATA_W-1:0] controlView;
    wire logic [DATA_W-1:0] statusFixed;
    logic [DATA_W-1:0] statusView;
    logic [DATA_W-1:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Link qualification

    assign lq.syncRaw = syncStatus;

    // Filtering keeps a brief sync dropout from clearing the link latch
    sync_loss_filter #(
        .TIMER_CYCLES(LINK_TIMER)
    ) syncFilter (
        .clock(clock),
        .rst(rst),
        .lq(lq)
    );

    // Negotiation only counts when enabled
    assign negotiationOk = anComplete || !anEnable;
    assign linkGood = lq.syncQualified && negotiationOk && resetDone;

    assign statusRead = mgmtRead && isReg(mgmtAddr, ADDR_STATUS);
    assign controlWrite = mgmtWrite && isReg(mgmtAddr, ADDR_CONTROL_LOW);
    // Outside controller mode the stored bit is frozen
    assign speedWrite = controlWrite && controllerMode;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            speedMsbStore <= CTL_SPEED_MSB_RESET;
        end else if (speedWrite) begin
            speedMsbStore <= mgmtWdata[CTL_SPEED_MSB_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            unidirEnable <= CTL_UNIDIR_RESET;
        end else if (controlWrite) begin
            unidirEnable <= mgmtWdata[CTL_UNIDIR_BIT];
        end
    end

    // Fixed 1 outside controller mode
    assign speedSelectMsb = controllerMode ? speedMsbStore : 1'b1;

    // Written values outside bits 6 and 5 are never stored
    for (genvar ci = 0; ci < DATA_W; ci++) begin : g_control_view
        assign controlView[ci] = controlBit(ci, speedSelectMsb, unidirEnable);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status latches

    // A fault in the read cycle survives the clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            remoteFault <= ST_REMOTE_FAULT_RESET;
        end else if (remoteFaultEvent) begin
            remoteFault <= 1'b1;
        end else if (statusRead) begin
            remoteFault <= 1'b0;
        end
    end

    // Reload on read is the live state, so a loss in that cycle still shows
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            linkLatched <= ST_LINK_RESET;
        end else if (statusRead) begin
            linkLatched <= linkGood;
        end else begin
            linkLatched <= linkLatched && linkGood;
        end
    end

    // Constant ability bits, one position at a time
    for (genvar si = 0; si < DATA_W; si++) begin : g_status_fixed
        assign statusFixed[si] = fixedStatusBit(si);
    end

    // Live and latched fields overlay the constant bits
    always_comb begin
        statusView = statusFixed;
        statusView[ST_AN_COMPLETE_BIT] = anComplete;
        statusView[ST_REMOTE_FAULT_BIT] = remoteFault;
        statusView[ST_LINK_BIT] = linkLatched;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped indices read zero; this port has no error response
    always_comb begin
        if (isReg(mgmtAddr, ADDR_CONTROL_LOW)) begin
            next_rdata = controlView;
        end else if (isReg(mgmtAddr, ADDR_STATUS)) begin
            next_rdata = statusView;
        end else begin
            next_rdata = '0;
        end
    end

    // Data is captured from the pre-clear latches at the read edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mgmtRdata <= '0;
        end else if (mgmtRead) begin
            mgmtRdata <= next_rdata;
        end
    end

    // One pulse per read strobe, whatever the address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mgmtRvalid <= 1'b0;
        end else begin
            mgmtRvalid <= mgmtRead;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/sgmii_mgmt_checker.sv
// Checker for the management register bank, bound to its ports.
// Assumes one clock and the async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sgmii_mgmt_checker
    import sgmii_mgmt_pkg::*;
#(
    parameter int unsigned LINK_TIMER = LINK_TIMER_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Management access
    input wire logic mgmtWrite,
    input wire logic mgmtRead,
    input wire logic [ADDR_W-1:0] mgmtAddr,
    input wire logic [DATA_W-1:0] mgmtWdata,
    input wire logic [DATA_W-1:0] mgmtRdata,
    input wire logic mgmtRvalid,
    // Mode and link state
    input wire logic controllerMode,
    input wire logic syncStatus,
    input wire logic anEnable,
    input wire logic anComplete,
    input wire logic resetDone,
    input wire logic remoteFaultEvent,
    // Control outputs
    input wire logic speedSelectMsb,
    input wire logic unidirEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic rdSt;
    logic lostSeen;
    int lowCnt;
    assign rdSt = mgmtRead && mgmtAddr == ADDR_STATUS;
    // Loss is remembered until a status read, like the latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            lowCnt <= 0;
        else
            lowCnt <= syncStatus ? 0 : lowCnt + 1;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            lostSeen <= 1'b0;
        else if (rdSt)
            lostSeen <= 1'b0;
        else if (lowCnt == LINK_TIMER + 3)
            lostSeen <= 1'b1;
    end
    a_read_answer: assert property (mgmtRead |=> mgmtRvalid)
        else $error("read without answer");
    a_no_spurious: assert property (!mgmtRead |=> !mgmtRvalid)
        else $error("answer without read");
    a_status_const: assert property (rdSt |=> mgmtRdata[15:9] == 7'h00 &&
        mgmtRdata[1:0] == 2'h0) else $error("status constant bits");
    a_status_able: assert property (
        rdSt |=> mgmtRdata[8:6] == 3'h7 && mgmtRdata[3]) else $error("status ability bits");
    a_ctl_low: assert property (mgmtRead && mgmtAddr == ADDR_CONTROL_LOW |=>
        mgmtRdata[4:0] == 5'h00 && mgmtRdata[6] == $past(speedSelectMsb))
        else $error("control low bits");
    a_speed_fixed: assert property (!controllerMode |-> speedSelectMsb)
        else $error("speed bit not fixed");
    a_speed_write: assert property (mgmtWrite && mgmtAddr == ADDR_CONTROL_LOW &&
        controllerMode |=> !controllerMode || speedSelectMsb == $past(mgmtWdata[6]))
        else $error("speed bit write");
    a_an_live: assert property (rdSt |=> mgmtRdata[5] == $past(anComplete))
        else $error("negotiation bit");
    a_fault_set: assert property (remoteFaultEvent ##1 rdSt |=> mgmtRdata[4])
        else $error("fault not seen");
    a_link_lost: assert property (rdSt && lostSeen |=> !mgmtRdata[2])
        else $error("link loss not latched");
    a_reset_gate: assert property (!resetDone ##1 (!resetDone && rdSt) |=>
        !mgmtRdata[2]) else $error("link up in reset");
    cover property (rdSt ##1 mgmtRdata[2]);
    cover property (remoteFaultEvent ##1 rdSt);
    cover property (mgmtWrite && controllerMode);
endmodule
bind sgmii_mgmt_regs sgmii_mgmt_checker #(.LINK_TIMER(LINK_TIMER)) sgmii_mgmt_checker_inst (
    .clock(clock), .rst(rst), .mgmtWrite(mgmtWrite), .mgmtRead(mgmtRead),
    .mgmtAddr(mgmtAddr), .mgmtWdata(mgmtWdata), .mgmtRdata(mgmtRdata),
    .mgmtRvalid(mgmtRvalid), .controllerMode(controllerMode), .syncStatus(syncStatus),
    .anEnable(anEnable), .anComplete(anComplete), .resetDone(resetDone),
    .remoteFaultEvent(remoteFaultEvent), .speedSelectMsb(speedSelectMsb),
    .unidirEnable(unidirEnable));
`default_nettype wire

// ===== testbench/mgmt_station.sv
// Management station: one-cycle read and write strobes.
// Assumes the bench calls its tasks; changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
    import sgmii_mgmt_pkg::*;
(
    // Clock
    input wire logic clock,
    // Bus
    output logic mgmtWrite,
    output logic mgmtRead,
    output logic [ADDR_W-1:0] mgmtAddr,
    output logic [DATA_W-1:0] mgmtWdata,
    input wire logic [DATA_W-1:0] mgmtRdata,
    input wire logic mgmtRvalid
);
    initial begin
        mgmtWrite = 1'b0;
        mgmtRead = 1'b0;
        mgmtAddr = '0;
        mgmtWdata = '0;
    end
    // Idle lines flip so a stale value never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        mgmtWrite = 1'b1;
        mgmtAddr = a;
        mgmtWdata = d;
        @(negedge clock);
        mgmtWrite = 1'b0;
        mgmtAddr = ~a;
        mgmtWdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(negedge clock);
        mgmtRead = 1'b1;
        mgmtAddr = a;
        @(negedge clock);
        mgmtRead = 1'b0;
        mgmtAddr = ~a;
        d = mgmtRdata;
        v = mgmtRvalid;
    endtask
endmodule
`default_nettype wire

// ===== testbench/sgmii_mgmt_control_status_regs_test.sv
// Self-checking bench for the management register bank.
// Assumes a short link timer parameter.
`timescale 1ns/1ps
`default_nettype none
module sgmii_mgmt_control_status_regs_test;
    import sgmii_mgmt_pkg::*;
    localparam int LT = 8;
    logic clock, rst, mode, sync, anEn, anDone, rstDone, fault, wE, rE, rV, spd, uni, v;
    logic [4:0] ad;
    logic [15:0] wD, rD, d, w, e;
    logic spdM;
    int n_fail, check_count;
    mgmt_station mgmt_station_inst (.clock(clock), .mgmtWrite(wE), .mgmtRead(rE),
        .mgmtAddr(ad), .mgmtWdata(wD), .mgmtRdata(rD), .mgmtRvalid(rV));
    sgmii_mgmt_regs #(.LINK_TIMER(LT)) sgmii_mgmt_regs_inst (.clock(clock), .rst(rst),
        .mgmtWrite(wE), .mgmtRead(rE), .mgmtAddr(ad), .mgmtWdata(wD), .mgmtRdata(rD),
        .mgmtRvalid(rV), .controllerMode(mode), .syncStatus(sync), .anEnable(anEn),
        .anComplete(anDone), .resetDone(rstDone), .remoteFaultEvent(fault),
        .speedSelectMsb(spd), .unidirEnable(uni));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] stat(input logic l, input logic f);
        return 16'h01C8 | {10'h000, anDone, f, 1'b0, l, 2'h0};
    endfunction
    task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] g);
        check_count++;
        if (g !== ex) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic rds(input logic [15:0] ex);
        mgmt_station_inst.rd(ADDR_STATUS, d, v);
        cmp("valid", 16'h0001, {15'h0000, v});
        cmp("status", ex, d);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #30000;
        n_fail++;
        test_done;
    end
    initial begin
        {mode, sync, anEn, anDone, rstDone, fault} = '0;
        rst = 1'b1;
        spdM = 1'b1;
        void'($urandom(32'h14B201D7));
        repeat (3) @(negedge clock);
        rst = 1'b0;
        mgmt_station_inst.rd(ADDR_CONTROL_LOW, d, v);
        cmp("control", 16'h0040, d);
        rds(stat(0, 0));
        for (int i = 0; i < 8; i++) begin
            mode = i[1];
            w = $urandom;
            mgmt_station_inst.wr(ADDR_CONTROL_LOW, w);
            if (mode)
                spdM = w[6];
            e = {9'h000, mode ? spdM : 1'b1, w[5], 5'h00};
            mgmt_station_inst.rd(ADDR_CONTROL_LOW, d, v);
            cmp("control", e, d);
            cmp("outputs", {14'h0000, e[6:5]}, {14'h0000, spd, uni});
            // Status and unmapped places ignore writes
            mgmt_station_inst.wr(ADDR_STATUS, ~w);
            mgmt_station_inst.wr(5'($urandom_range(31, 2)), w);
            mgmt_station_inst.rd(5'($urandom_range(31, 2)), d, v);
            cmp("unmapped", 16'h0000, d);
        end
        rds(stat(0, 0));
        {sync, rstDone} = 2'b11;
        repeat (4) @(negedge clock);
        rds(stat(0, 0));
        rds(stat(1, 0));
        sync = 1'b0;
        repeat (LT - 3) @(negedge clock);
        sync = 1'b1;
        rds(stat(1, 0));
        sync = 1'b0;
        repeat (LT + 4) @(negedge clock);
        sync = 1'b1;
        repeat (3) @(negedge clock);
        rds(stat(0, 0));
        rds(stat(1, 0));
        for (int k = 0; k < 2; k++) begin
            anEn = 1'b1;
            anDone = k[0];
            rstDone = !k[0];
            repeat (2) @(negedge clock);
            rds(stat(0, 0));
            {anDone, rstDone} = 2'b11;
            rds(stat(0, 0));
            rds(stat(1, 0));
        end
        // Fault held into a read: the set outlasts that read's clear
        fault = 1'b1;
        rds(stat(1, 1));
        fault = 1'b0;
        rds(stat(1, 1));
        rds(stat(1, 0));
        fault = 1'b1;
        @(negedge clock);
        fault = 1'b0;
        rds(stat(1, 1));
        rds(stat(1, 0));
        // Reset in mid-run returns every stored field to its reset value
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        mgmt_station_inst.rd(ADDR_CONTROL_LOW, d, v);
        cmp("control", 16'h0040, d);
        rds(stat(0, 0));
        rds(stat(1, 0));
        test_done;
    end
endmodule
`default_nettype wire
